// [include/cfacc_map.vh]
// Purpose: register map, field positions, reset values and codes of the card command block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   included by bare name; definitions only
`ifndef CFACC_MAP_VH
`define CFACC_MAP_VH

// register byte offsets
`define CFACC_CTRL_OFS      6'h00
`define CFACC_PARAM_OFS     6'h04
`define CFACC_TARGET_OFS    6'h08
`define CFACC_ACCESS_OFS    6'h0C
`define CFACC_DATA0_OFS     6'h10
`define CFACC_DATA3_OFS     6'h1C
`define CFACC_SECRET0_OFS   6'h20
`define CFACC_SECRET1_OFS   6'h24
`define CFACC_STATUS_OFS    6'h28
`define CFACC_RESULT_OFS    6'h2C
`define CFACC_LCS_OFS       6'h30
`define CFACC_PIN0_OFS      6'h34
`define CFACC_PIN1_OFS      6'h38

// CTRL fields: bit 0 go, bits 3:1 command kind
`define CFACC_CTRL_GO_BIT   0
`define CFACC_KIND_LSB      1
`define CFACC_KIND_MSB      3

// command kinds
`define CFACC_K_UNBLOCK     3'h0
`define CFACC_K_DEACT       3'h1
`define CFACC_K_ACT         3'h2
`define CFACC_K_AUTH        3'h3
`define CFACC_K_CHAN        3'h4
`define CFACC_K_FILEOP      3'h5
`define CFACC_K_SELECT      3'h6

// ACCESS fields
`define CFACC_AC_DEACT_BIT  0
`define CFACC_AC_ACT_BIT    1
`define CFACC_AC_APP_BIT    2
`define CFACC_AC_FOUND_BIT  3

// TARGET fields: bits 2:0 file index, bits 6:4 directory index, bit 8 data present
`define CFACC_TGT_DATA_BIT  8

// parameter codes
`define CFACC_P1_BY_FID     8'h00
`define CFACC_P1_PATH_MF    8'h08
`define CFACC_P1_PATH_DF    8'h09
`define CFACC_P1_OPEN       8'h00
`define CFACC_P1_CLOSE      8'h80
`define CFACC_LC_UNBLOCK    8'h10

// retry counts and reset values
`define CFACC_UB_RETRY_INIT 4'hA
`define CFACC_PIN_RETRY_INIT 2'h3
`define CFACC_SW_RESET      16'h9000

// status words
`define CFACC_SW_OK         16'h9000
`define CFACC_SW_BAD_P1P2   16'h6A86
`define CFACC_SW_BAD_LEN    16'h6700
`define CFACC_SW_SECURITY   16'h6982
`define CFACC_SW_BLOCKED    16'h6983
`define CFACC_SW_COND       16'h6985
`define CFACC_SW_NO_EF      16'h6986
`define CFACC_SW_NOT_FOUND  16'h6A82
`define CFACC_SW_NO_CHAN    16'h6A81
`define CFACC_SW_RETRY      12'h63C

`endif

// [design/cfacc_top.v]
// Purpose: card-side handler for unblock, file (de)activation, authenticate and channel commands
// Assumes: firmware resolves file ids/paths to indices and fills ACCESS before go
// Notes:   every command completes in the cycle after the go write
//
// Contract
// - unblock: P1 zero, Lc empty or sixteen
// - deactivation sets file life-cycle flag, reversible
// - deactivate only when its access condition holds
// - success makes target the current file
// - failure leaves current file and directory untouched
// - deactivated file refuses all but select, activate; here only file work is refused, deactivate of it still succeeds
// - P1: 00 fid, 08 path MF, 09 path DF
// - P2 zero; empty P1/P2/data targets current file
// - activation clears flag, gated by access condition
// - failed activation condition leaves file state unchanged
// - authenticate starts computation; P1 zero implies algorithm
// - auth P2: b8 scope, b7b6 zero, ref 01-1F
// - auth P2 zero uses application implied key
// - Lc bytes in, Le bytes out
// - open never allocates basic channel zero
// - card picks the new channel number
// - closed channel returns to free pool
// - channel zero always open, close rejected
// - return number only when card allocated it
// - P1 00 open, 80 close; P2 1-3 close only
// - channel byte only when P1 and P2 zero
// - good unblock: new PIN, counts ten/three, enable
`timescale 1ns/100ps
`default_nettype none
`include "cfacc_map.vh"

module cfacc_top
(
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb request
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  // apb answer
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  // engine side
  output reg         auth_start_ff,
  output reg         cmd_done_ff
);

  // bus strobes
  wire        acc_ok;                 // access phase with slave ready
  wire        wr_en;                  // write takes effect this edge
  wire        setup;                  // setup phase seen this edge
  wire [5:0]  ofs;                    // word-aligned register offset
  wire        go;                     // command start strobe
  wire [2:0]  kind;                   // command kind from pwdata

  // software-written registers
  reg  [31:0] param_ff;               // p1, p2, lc, le
  reg  [8:0]  target_ff;              // resolved target and data present
  reg  [3:0]  access_ff;              // access conditions and lookup result
  reg  [31:0] data_ff [0:3];          // sixteen data field bytes
  reg  [31:0] secret_ff [0:1];        // stored unblock secret, write only

  // block state
  reg  [31:0] pin_ff [0:1];           // installed pin value
  reg  [15:0] sw_ff;                  // status word of last command
  reg  [2:0]  cur_ef_ff;              // current elementary file
  reg         cur_ef_vld_ff;          // a current file exists
  reg  [2:0]  cur_df_ff;              // current directory
  reg  [3:1]  chan_ff;                // open logical channels 1-3
  reg  [7:0]  resp_chan_ff;           // channel number answer
  reg         resp_vld_ff;            // answer byte present
  reg  [3:0]  ub_retry_ff;            // unblock attempts left
  reg  [1:0]  pin_retry_ff;           // pin attempts left
  reg         pin_en_ff;              // pin enabled
  reg         ub_blk_ff;              // unblock secret blocked
  reg  [7:0]  deact_ff;               // life_cycle_status_object flags
  reg  [4:0]  key_ref_ff;             // authentication key reference
  reg         key_spec_ff;            // specific rather than global key
  reg         key_impl_ff;            // key implied by application
  reg  [7:0]  auth_lc_ff;             // challenge length handed on
  reg  [7:0]  auth_le_ff;             // response length expected

  // next values
  reg  [15:0] nxt_sw;
  reg  [2:0]  nxt_cur_ef, nxt_cur_df;
  reg  [3:1]  nxt_chan;
  reg  [7:0]  nxt_resp_chan, nxt_deact;
  reg  [3:0]  nxt_ub_retry;
  reg  [1:0]  nxt_pin_retry;
  reg  [4:0]  nxt_key_ref;
  reg  [31:0] nxt_rdata;
  reg         nxt_cur_ef_vld, nxt_resp_vld, nxt_pin_en, nxt_ub_blk, nxt_pin_load;
  reg         nxt_key_spec, nxt_key_impl, nxt_auth_start, nxt_slverr;

  // decoded parameters
  wire [7:0]  p1, p2, lc;             // command parameters
  wire [2:0]  tgt;                    // file that the command acts on
  wire        use_cur;                // empty command targets current file

  // key reference check shared by unblock and authenticate
  function key_ref_ok;
    input [7:0] p;
    begin
      key_ref_ok = (p == 8'h00) || ((p[6:5] == 2'h0) && (p[4:0] != 5'h00));
    end
  endfunction

  // lowest free channel, zero when none is free
  function [1:0] free_chan;
    input [3:1] open;
    begin
      free_chan = !open[1] ? 2'h1 : !open[2] ? 2'h2 : !open[3] ? 2'h3 : 2'h0;
    end
  endfunction

  assign acc_ok = psel & penable & pready_ff;
  assign wr_en  = acc_ok & pwrite;
  assign setup  = psel & ~penable;
  assign ofs    = {paddr[5:2], 2'h0};
  assign kind   = pwdata[`CFACC_KIND_MSB:`CFACC_KIND_LSB];
  assign go     = wr_en & (ofs == `CFACC_CTRL_OFS) & (paddr[31:6] == 26'h0)
                  & pwdata[`CFACC_CTRL_GO_BIT];
  assign p1     = param_ff[7:0];
  assign p2     = param_ff[15:8];
  assign lc     = param_ff[23:16];
  assign use_cur = (p1 == 8'h00) && (p2 == 8'h00) && !target_ff[`CFACC_TGT_DATA_BIT];
  assign tgt    = use_cur ? cur_ef_ff : target_ff[2:0];

  // command execution; state is held unless a branch succeeds, except status word, answer flag, unblock retries and block flag
  always @*
  begin
    nxt_sw         = sw_ff;
    nxt_cur_ef     = cur_ef_ff;
    nxt_cur_ef_vld = cur_ef_vld_ff;
    nxt_cur_df     = cur_df_ff;
    nxt_chan       = chan_ff;
    nxt_resp_chan  = resp_chan_ff;
    nxt_resp_vld   = resp_vld_ff;
    nxt_ub_retry   = ub_retry_ff;
    nxt_pin_retry  = pin_retry_ff;
    nxt_pin_en     = pin_en_ff;
    nxt_ub_blk     = ub_blk_ff;
    nxt_pin_load   = 1'b0;
    nxt_deact      = deact_ff;
    nxt_key_ref    = key_ref_ff;
    nxt_key_spec   = key_spec_ff;
    nxt_key_impl   = key_impl_ff;
    nxt_auth_start = 1'b0;
    if (go)
    begin
      nxt_resp_vld = 1'b0;
      case (kind)
        `CFACC_K_UNBLOCK:
        begin
          if (p1 != 8'h00 || !key_ref_ok(p2) || p2 == 8'h00)
            nxt_sw = `CFACC_SW_BAD_P1P2;
          else if (lc != 8'h00 && lc != `CFACC_LC_UNBLOCK)
            nxt_sw = `CFACC_SW_BAD_LEN;
          else if (ub_blk_ff)
            nxt_sw = `CFACC_SW_BLOCKED;
          else if (lc == 8'h00)
            nxt_sw = {`CFACC_SW_RETRY, ub_retry_ff}; // retry count query
          else if ({data_ff[0], data_ff[1]} == {secret_ff[0], secret_ff[1]})
          begin
            // bytes 9 to 16 become the new pin
            nxt_pin_load  = 1'b1;
            nxt_ub_retry  = `CFACC_UB_RETRY_INIT;
            nxt_pin_retry = `CFACC_PIN_RETRY_INIT;
            nxt_pin_en    = 1'b1;
            nxt_sw        = `CFACC_SW_OK;
          end
          else
          begin
            // a wrong secret never touches the pin itself
            nxt_ub_retry = ub_retry_ff - 4'h1;
            nxt_ub_blk   = (ub_retry_ff == 4'h1);
            nxt_sw       = {`CFACC_SW_RETRY, ub_retry_ff - 4'h1};
          end
        end
        `CFACC_K_DEACT,
        `CFACC_K_ACT:
        begin
          // failures below change neither current file nor directory
          if ((p1 != `CFACC_P1_BY_FID && p1 != `CFACC_P1_PATH_MF &&
               p1 != `CFACC_P1_PATH_DF) || p2 != 8'h00)
            nxt_sw = `CFACC_SW_BAD_P1P2;
          else if (use_cur && !cur_ef_vld_ff)
            nxt_sw = `CFACC_SW_NO_EF;
          else if (!use_cur && !access_ff[`CFACC_AC_FOUND_BIT])
            nxt_sw = `CFACC_SW_NOT_FOUND;
          else if (kind == `CFACC_K_DEACT && !access_ff[`CFACC_AC_DEACT_BIT])
            nxt_sw = `CFACC_SW_SECURITY;
          else if (kind == `CFACC_K_ACT && !access_ff[`CFACC_AC_ACT_BIT])
            nxt_sw = `CFACC_SW_SECURITY;
          else
          begin
            nxt_deact[tgt] = (kind == `CFACC_K_DEACT);
            nxt_cur_ef     = tgt;
            nxt_cur_ef_vld = 1'b1;
            nxt_sw         = `CFACC_SW_OK;
          end
        end
        `CFACC_K_AUTH:
        begin
          if (p1 != 8'h00 || !key_ref_ok(p2))
            nxt_sw = `CFACC_SW_BAD_P1P2;
          else if (!access_ff[`CFACC_AC_APP_BIT])
            nxt_sw = `CFACC_SW_COND;
          else
          begin
            nxt_key_impl   = (p2 == 8'h00);
            nxt_key_spec   = p2[7];
            nxt_key_ref    = p2[4:0];
            nxt_auth_start = 1'b1;
            nxt_sw         = `CFACC_SW_OK;
          end
        end
        `CFACC_K_CHAN:
        begin
          if (p1 == `CFACC_P1_OPEN && p2 == 8'h00)
          begin
            if (free_chan(chan_ff) == 2'h0)
              nxt_sw = `CFACC_SW_NO_CHAN;
            else
            begin
              // channel zero is never in the pool
              nxt_chan[free_chan(chan_ff)] = 1'b1;
              nxt_resp_chan = {6'h00, free_chan(chan_ff)};
              nxt_resp_vld  = 1'b1;
              nxt_sw        = `CFACC_SW_OK;
            end
          end
          else if (p1 == `CFACC_P1_CLOSE && p2 >= 8'h01 && p2 <= 8'h03)
          begin
            nxt_chan[p2[1:0]] = 1'b0;
            nxt_sw            = `CFACC_SW_OK;
          end
          else
            nxt_sw = `CFACC_SW_BAD_P1P2;
        end
        `CFACC_K_FILEOP:
        begin
          if (!cur_ef_vld_ff)
            nxt_sw = `CFACC_SW_NO_EF;
          else if (deact_ff[cur_ef_ff])
            nxt_sw = `CFACC_SW_COND;
          else
            nxt_sw = `CFACC_SW_OK;
        end
        `CFACC_K_SELECT:
        begin
          // selection stays allowed on a deactivated file
          if (!access_ff[`CFACC_AC_FOUND_BIT])
            nxt_sw = `CFACC_SW_NOT_FOUND;
          else
          begin
            nxt_cur_ef     = target_ff[2:0];
            nxt_cur_ef_vld = 1'b1;
            nxt_cur_df     = target_ff[6:4];
            nxt_sw         = `CFACC_SW_OK;
          end
        end
        default:
          nxt_sw = `CFACC_SW_BAD_P1P2;
      endcase
    end
  end

  // read mux, sampled in the setup phase; secrets read as zero
  always @*
  begin
    nxt_rdata  = 32'h0000_0000;
    nxt_slverr = 1'b0;
    if (paddr[31:6] != 26'h0)
      nxt_slverr = 1'b1;
    else
      case (ofs)
        `CFACC_CTRL_OFS, `CFACC_SECRET0_OFS, `CFACC_SECRET1_OFS: nxt_rdata = 32'h0000_0000;
        `CFACC_PARAM_OFS:   nxt_rdata = param_ff;
        `CFACC_TARGET_OFS:  nxt_rdata = {23'h000000, target_ff};
        `CFACC_ACCESS_OFS:  nxt_rdata = {28'h0000000, access_ff};
        `CFACC_STATUS_OFS:
          nxt_rdata = {4'h0, chan_ff, 1'b1, cur_df_ff, cur_ef_vld_ff, cur_ef_ff, 1'b0, sw_ff};
        `CFACC_RESULT_OFS:
          nxt_rdata = {8'h00, key_impl_ff, key_spec_ff, key_ref_ff, ub_blk_ff, pin_en_ff,
                       pin_retry_ff, ub_retry_ff, resp_vld_ff, resp_chan_ff};
        `CFACC_LCS_OFS:     nxt_rdata = {auth_le_ff, auth_lc_ff, 8'h00, deact_ff};
        `CFACC_PIN0_OFS:    nxt_rdata = pin_ff[0];
        `CFACC_PIN1_OFS:    nxt_rdata = pin_ff[1];
        default:
          if (ofs >= `CFACC_DATA0_OFS && ofs <= `CFACC_DATA3_OFS)
            nxt_rdata = data_ff[ofs[3:2]];
          else
            nxt_slverr = 1'b1;
      endcase
  end

  // apb answer: ready in the first access cycle, no wait states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup & nxt_slverr;
      prdata_ff  <= (setup & ~pwrite) ? nxt_rdata : 32'h0000_0000;
    end
  end

  // software-written registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      param_ff     <= 32'h0000_0000;
      target_ff    <= 9'h000;
      access_ff    <= 4'h0;
      data_ff[0]   <= 32'h0000_0000;
      data_ff[1]   <= 32'h0000_0000;
      data_ff[2]   <= 32'h0000_0000;
      data_ff[3]   <= 32'h0000_0000;
      secret_ff[0] <= 32'h0000_0000;
      secret_ff[1] <= 32'h0000_0000;
    end
    else if (wr_en && paddr[31:6] == 26'h0)
    begin
      if (ofs == `CFACC_PARAM_OFS)
        param_ff <= pwdata;
      if (ofs == `CFACC_TARGET_OFS)
        target_ff <= pwdata[8:0];
      if (ofs == `CFACC_ACCESS_OFS)
        access_ff <= pwdata[3:0];
      if (ofs >= `CFACC_DATA0_OFS && ofs <= `CFACC_DATA3_OFS)
        data_ff[ofs[3:2]] <= pwdata;
      if (ofs == `CFACC_SECRET0_OFS)
        secret_ff[0] <= pwdata;
      if (ofs == `CFACC_SECRET1_OFS)
        secret_ff[1] <= pwdata;
    end
  end

  // block state update
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_ff         <= `CFACC_SW_RESET;
      cur_ef_ff     <= 3'h0;
      cur_ef_vld_ff <= 1'b0;
      cur_df_ff     <= 3'h0;
      chan_ff       <= 3'h0;
      resp_chan_ff  <= 8'h00;
      resp_vld_ff   <= 1'b0;
      ub_retry_ff   <= `CFACC_UB_RETRY_INIT;
      pin_retry_ff  <= `CFACC_PIN_RETRY_INIT;
      pin_en_ff     <= 1'b1;
      ub_blk_ff     <= 1'b0;
      deact_ff      <= 8'h00;
      key_ref_ff    <= 5'h00;
      key_spec_ff   <= 1'b0;
      key_impl_ff   <= 1'b0;
      auth_lc_ff    <= 8'h00;
      auth_le_ff    <= 8'h00;
      pin_ff[0]     <= 32'h0000_0000;
      pin_ff[1]     <= 32'h0000_0000;
      auth_start_ff <= 1'b0;
      cmd_done_ff   <= 1'b0;
    end
    else
    begin
      sw_ff         <= nxt_sw;
      cur_ef_ff     <= nxt_cur_ef;
      cur_ef_vld_ff <= nxt_cur_ef_vld;
      cur_df_ff     <= nxt_cur_df;
      chan_ff       <= nxt_chan;
      resp_chan_ff  <= nxt_resp_chan;
      resp_vld_ff   <= nxt_resp_vld;
      ub_retry_ff   <= nxt_ub_retry;
      pin_retry_ff  <= nxt_pin_retry;
      pin_en_ff     <= nxt_pin_en;
      ub_blk_ff     <= nxt_ub_blk;
      deact_ff      <= nxt_deact;
      key_ref_ff    <= nxt_key_ref;
      key_spec_ff   <= nxt_key_spec;
      key_impl_ff   <= nxt_key_impl;
      auth_start_ff <= nxt_auth_start;
      cmd_done_ff   <= go;
      // lengths handed to the algorithm engine with the start pulse
      if (nxt_auth_start)
      begin
        auth_lc_ff <= lc;
        auth_le_ff <= param_ff[31:24];
      end
      if (nxt_pin_load)
      begin
        pin_ff[0] <= data_ff[2];
        pin_ff[1] <= data_ff[3];
      end
    end
  end

endmodule
`default_nettype wire

// [tb/cfacc_term.sv]
// Purpose: terminal-side model that reaches the card block over apb
// Assumes: slave raises pready
// Notes:   idle lines show the inverse
`timescale 1ns/100ps
`default_nettype none
module cfacc_term
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb request
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [31:0] paddr,
  output var  logic [31:0] pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // bus idle at time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
  end

  // one transfer; waits for pready
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask

  // one command, go write last
  task automatic apdu(input logic [2:0] k, input logic [31:0] prm, input logic [8:0] t,
                      input logic [3:0] ac);
    logic [31:0] x;
    logic        e;
    xfer(1'b1, 32'h4, prm, x, e);
    xfer(1'b1, 32'h8, {23'h0, t}, x, e);
    xfer(1'b1, 32'hC, {28'h0, ac}, x, e);
    xfer(1'b1, 32'h0, {28'h0, k, 1'b1}, x, e);
  endtask
endmodule
`default_nettype wire

// [tb/cfacc_top_props.sv]
// Purpose: port-level checks of the card command block
// Assumes: zero-wait apb
// Notes:   bound at the foot
`timescale 1ns/100ps
`default_nettype none
module cfacc_top_props
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb request
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata_ff,
  input wire logic        pready_ff,
  input wire logic        pslverr_ff,
  // engine side
  input wire logic        auth_start_ff,
  input wire logic        cmd_done_ff
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic go_w = psel && penable && pready_ff && pwrite && paddr == 32'h0 && pwdata[0];

  // setup cycle of a transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  // accepted write of the go bit
  sequence s_go;
    go_w;
  endsequence

  a_ready_after_setup: assert property (s_setup |=> pready_ff)
    else $error("no answer one cycle after setup");
  a_ready_one_cycle: assert property (pready_ff |=> !pready_ff)
    else $error("answer held too long");
  a_ready_in_access: assert property (pready_ff |-> psel && penable)
    else $error("answer outside an access cycle");
  a_err_high_addr: assert property (psel && penable && pready_ff && paddr[31:6] != 26'h0
    |-> pslverr_ff) else $error("high address not refused");
  a_err_with_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("error without answer");
  a_rdata_quiet: assert property (!pready_ff || pwrite |-> prdata_ff == 32'h0)
    else $error("stray read data");
  a_go_done: assert property (s_go |=> cmd_done_ff ##1 !cmd_done_ff)
    else $error("go not completed");
  a_done_no_go: assert property (!go_w |=> !cmd_done_ff)
    else $error("completion without go");
  a_auth_with_done: assert property (auth_start_ff |-> cmd_done_ff)
    else $error("authenticate start outside completion");
endmodule
bind cfacc_top cfacc_top_props cfacc_top_props_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
  .auth_start_ff(auth_start_ff), .cmd_done_ff(cmd_done_ff));
`default_nettype wire

// [tb/cfacc_top_tb.sv]
// Purpose: self-checking bench for the card command block
// Assumes: terminal model drives apb
// Notes:   fixed seed, hand corners
`timescale 1ns/100ps
`default_nettype none
`include "cfacc_map.vh"
module cfacc_top_tb;
  logic        pclk, presetn;          // bus clock and reset
  logic        psel, penable, pwrite;  // apb request
  logic [31:0] paddr, pwdata;          // apb address and data
  logic [31:0] prdata_ff;              // read data
  logic        pready_ff, pslverr_ff;  // apb answer
  logic        auth_start_ff, cmd_done_ff; // engine pulses
  logic [31:0] st, rs, lc, q;          // status, result, life cycle, scratch
  logic [31:0] s0, s1, d2, d3;         // unblock secret and new pin
  logic [7:0]  p1s [3] = '{8'h00, 8'h08, 8'h09}; // selection codes
  logic [7:0]  p2;                     // authenticate key byte
  logic        e, ast;                 // refusal and start seen
  integer      error_cnt = 0;          // mismatches
  integer      compares = 0;           // comparisons made
  integer      cyc = 0, i;             // hang guard cycles, loop index
  integer      seed = 32'hA53F727C;    // fixed seed keeps runs repeatable

  cfacc_term cfacc_term_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_ff),
    .pready(pready_ff), .pslverr(pslverr_ff));
  cfacc_top cfacc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .auth_start_ff(auth_start_ff),
    .cmd_done_ff(cmd_done_ff));

  // expected key fields: implied, specific, number
  function automatic logic [6:0] key_exp(input logic [7:0] p);
    key_exp = {p == 8'h00, p[7], p[4:0]};
  endfunction
  // expected status word with retries left
  function automatic logic [15:0] retry_sw(input logic [3:0] n);
    retry_sw = {`CFACC_SW_RETRY, n};
  endfunction

  // verdict, single exit of the run
  task automatic wrap_up;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one counted comparison
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic swc(input logic [15:0] x);
    chk("sw", {16'h0, x}, {16'h0, st[15:0]});
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    cfacc_term_i.xfer(1'b1, {26'h0, a}, d, q, e);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    cfacc_term_i.xfer(1'b0, {26'h0, a}, 32'h0, d, e);
  endtask
  // command, then the three result words
  task automatic run(input logic [2:0] k, input logic [31:0] prm, input logic [8:0] t,
                     input logic [3:0] ac);
    cfacc_term_i.apdu(k, prm, t, ac);
    #1;
    chk("done", 32'h1, {31'h0, cmd_done_ff});
    ast = auth_start_ff;
    rd(`CFACC_STATUS_OFS, st);
    rd(`CFACC_RESULT_OFS, rs);
    rd(`CFACC_LCS_OFS, lc);
  endtask

  // 20 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  initial
  begin
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CFACC_STATUS_OFS, st);
    chk("reset status", 32'h01009000, st & 32'h0F10FFFF);
    rd(`CFACC_RESULT_OFS, rs);
    chk("reset counts", 32'h7A, {25'h0, rs[15:9]});
    rd(6'h3C, q);
    chk("unmapped", 32'h1, {31'h0, e});
    cfacc_term_i.xfer(1'b1, 32'h40, 32'h1, q, e);
    chk("high addr", 32'h1, {31'h0, e});
    // deactivate files 1 to 3 by id, path from mf, path from df
    for (i = 0; i < 3; i++)
    begin
      run(`CFACC_K_DEACT, {24'h0, p1s[i]}, 9'h100 | 9'(i + 1), 4'hF);
      swc(`CFACC_SW_OK);
      chk("flag", 32'h1, {31'h0, lc[i + 1]});
      chk("cur ef", 32'h8 | (i + 1), {28'h0, st[20:17]});
    end
    // access condition fails: nothing moves
    run(`CFACC_K_DEACT, 32'h0, 9'h105, 4'hE);
    swc(`CFACC_SW_SECURITY);
    chk("flag", 32'h0, {31'h0, lc[5]});
    chk("cur ef", 32'hB, {28'h0, st[20:17]});
    // reserved codes, last with nonzero p2
    for (i = 0; i < 4; i++)
    begin
      q = $random(seed);
      if (q[7:0] == 8'h00 || q[7:0] == 8'h08 || q[7:0] == 8'h09)
        q[7:0] = 8'h40;
      run(`CFACC_K_DEACT, (i == 3) ? {16'h0, q[15:8] | 8'h01, 8'h00} : {24'h0, q[7:0]},
          9'h106, 4'hF);
      swc(`CFACC_SW_BAD_P1P2);
      chk("flag", 32'h0, {31'h0, lc[6]});
      chk("cur ef", 32'hB, {28'h0, st[20:17]});
    end
    // file work on the deactivated current file is refused; select still succeeds
    run(`CFACC_K_FILEOP, 32'h0, 9'h000, 4'hF);
    swc(`CFACC_SW_COND);
    run(`CFACC_K_SELECT, 32'h0, 9'h023, 4'hF);
    chk("select", 32'h2B, {25'h0, st[23:17]});
    // empty form acts on the current file, gated by its condition
    run(`CFACC_K_ACT, 32'h0, 9'h000, 4'hD);
    swc(`CFACC_SW_SECURITY);
    chk("flag", 32'h1, {31'h0, lc[3]});
    run(`CFACC_K_ACT, 32'h0, 9'h000, 4'hF);
    swc(`CFACC_SW_OK);
    chk("flag", 32'h0, {31'h0, lc[3]});
    // card picks channels 1 to 3, then runs out
    for (i = 1; i < 5; i++)
    begin
      run(`CFACC_K_CHAN, 32'h0, 9'h0, 4'hF);
      swc(i < 4 ? `CFACC_SW_OK : `CFACC_SW_NO_CHAN);
      if (i < 4)
        chk("chan", 32'h100 | i, {23'h0, rs[8:0]});
    end
    // closing channel 2 frees it, with no response byte
    run(`CFACC_K_CHAN, 32'h0280, 9'h0, 4'hF);
    chk("close", 32'h5, {28'h0, rs[8], st[27:25]});
    run(`CFACC_K_CHAN, 32'h0, 9'h0, 4'hF);
    chk("reopen", 32'h102, {23'h0, rs[8:0]});
    // basic channel stays; open never names a channel
    run(`CFACC_K_CHAN, 32'h0080, 9'h0, 4'hF);
    swc(`CFACC_SW_BAD_P1P2);
    chk("chan0", 32'h1, {31'h0, st[24]});
    run(`CFACC_K_CHAN, 32'h0100, 9'h0, 4'hF);
    swc(`CFACC_SW_BAD_P1P2);
    chk("no byte", 32'h0, {31'h0, rs[8]});
    // authenticate: implied key, then random
    for (i = 0; i < 5; i++)
    begin
      q = $random(seed);
      p2 = (i == 0) ? 8'h00 : {q[7], 2'b00, 5'(q[12:8] % 31 + 1)};
      run(`CFACC_K_AUTH, {q[31:16], p2, 8'h00}, 9'h0, 4'hF);
      swc(`CFACC_SW_OK);
      chk("start", 32'h1, {31'h0, ast});
      chk("key", {25'h0, key_exp(p2)}, {25'h0, rs[23:17]});
      chk("lens", {16'h0, q[31:16]}, {16'h0, lc[31:16]});
    end
    run(`CFACC_K_AUTH, 32'h4100, 9'h0, 4'hF);
    swc(`CFACC_SW_BAD_P1P2);
    chk("start", 32'h0, {31'h0, ast});
    run(`CFACC_K_AUTH, 32'h0100, 9'h0, 4'hB);
    swc(`CFACC_SW_COND);
    // unblock: errors, query, wrong then right secret
    s0 = $random(seed);
    s1 = $random(seed);
    d2 = $random(seed);
    d3 = $random(seed);
    wr(`CFACC_SECRET0_OFS, s0);
    wr(`CFACC_SECRET1_OFS, s1);
    wr(`CFACC_DATA0_OFS, s0 ^ 32'h1);
    wr(6'h14, s1);
    wr(6'h18, d2);
    wr(`CFACC_DATA3_OFS, d3);
    run(`CFACC_K_UNBLOCK, 32'h00100101, 9'h0, 4'hF);
    swc(`CFACC_SW_BAD_P1P2);
    run(`CFACC_K_UNBLOCK, 32'h00080100, 9'h0, 4'hF);
    swc(`CFACC_SW_BAD_LEN);
    run(`CFACC_K_UNBLOCK, 32'h00000100, 9'h0, 4'hF);
    swc(retry_sw(4'hA));
    run(`CFACC_K_UNBLOCK, 32'h00100100, 9'h0, 4'hF);
    swc(retry_sw(4'h9));
    wr(`CFACC_DATA0_OFS, s0);
    run(`CFACC_K_UNBLOCK, 32'h00100100, 9'h0, 4'hF);
    swc(`CFACC_SW_OK);
    chk("counts", 32'h7A, {25'h0, rs[15:9]});
    rd(`CFACC_PIN0_OFS, q);
    chk("pin0", d2, q);
    rd(`CFACC_PIN1_OFS, q);
    chk("pin1", d3, q);
    wrap_up();
  end
endmodule
`default_nettype wire
